// >>> design/adcc_top.sv
// adc conversion control with classic wishbone register slave
`timescale 1ns/10ps
module adcc_top #(
  parameter bit REDUCED_PINS = 1'b0,
  parameter int NUM_CH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // converter analog front end
  input wire logic [7:0] conv_code,
  output logic conv_power,
  output logic conv_sample,
  output logic [3:0] conv_channel,
  output logic [1:0] upper_group_en,
  // port logic path
  input wire logic [NUM_CH-1:0] pin_level,
  output logic [NUM_CH-1:0] pin_logic,
  // processor modes
  input wire logic wait_mode,
  input wire logic halt_mode,
  // interrupt
  output logic irq
);
  localparam int CH_W = adcc_pkg::CH_WIDTH;
  logic [7:0] result;
  logic [CH_W-1:0] channel_select;
  logic converter_on;
  logic conversion_complete_flag;
  adcc_pkg::adcc_state_type state;
  logic [1:0] div_cnt;
  logic adc_tick;
  logic [3:0] period_cnt;
  logic [15:0] stab_cnt;
  logic [adcc_pkg::EV_WIDTH-1:0] irq_status;
  logic [adcc_pkg::EV_WIDTH-1:0] irq_mask;
  logic halt_sync1, halt_sync2;
  logic [NUM_CH-1:0] pin_sync1, pin_sync2;
  logic [7:0] code_sync1, code_sync2;
  logic req, wr, rd;
  logic [7:0] idx;
  logic csr_wr, result_rd, status_rd, conv_end, abort_ev, mapped;
  logic [7:0] csr_view;
  logic [31:0] next_rdata;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign idx = {2'b00, wb_adr_i[7:2]};
  assign mapped = (idx == adcc_pkg::RESULT_INDEX) || (idx == adcc_pkg::CSR_INDEX) ||
                  (idx == adcc_pkg::IRQ_STATUS_INDEX) || (idx == adcc_pkg::IRQ_MASK_INDEX) ||
                  (idx == adcc_pkg::HALT_CTRL_INDEX);
  assign wr = req && wb_we_i && mapped && wb_sel_i[0];
  assign rd = req && !wb_we_i && mapped;
  assign csr_wr = wr && idx == adcc_pkg::CSR_INDEX;
  assign result_rd = rd && idx == adcc_pkg::RESULT_INDEX;
  assign status_rd = rd && idx == adcc_pkg::IRQ_STATUS_INDEX;
  assign conv_end = state == adcc_pkg::ADCC_CONV && adc_tick && period_cnt == 4'(adcc_pkg::CONV_PERIODS - 1);
  assign abort_ev = csr_wr && converter_on && state == adcc_pkg::ADCC_CONV;

  // input synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      halt_sync1 <= 1'b0;
      halt_sync2 <= 1'b0;
      pin_sync1 <= '0;
      pin_sync2 <= '0;
      code_sync1 <= 8'h00;
      code_sync2 <= 8'h00;
    end else begin
      halt_sync1 <= halt_mode;
      halt_sync2 <= halt_sync1;
      pin_sync1 <= pin_level;
      pin_sync2 <= pin_sync1;
      code_sync1 <= conv_code;
      code_sync2 <= code_sync1;
    end
  end

  // analog pins still read as logic
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_logic <= '0;
    end else begin
      pin_logic <= pin_sync2;
    end
  end

  // converter clock enable, system clock over four
  always_ff @(posedge ref_clk) begin
    if (!rstn || state == adcc_pkg::ADCC_OFF || csr_wr) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  assign adc_tick = div_cnt == 2'(adcc_pkg::CLK_DIV - 1);

  // control fields
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      converter_on <= 1'b0;
      channel_select <= 4'h0;
    end else if (csr_wr) begin
      converter_on <= wb_dat_i[adcc_pkg::ON_BIT];
      channel_select <= wb_dat_i[CH_W-1:0];
    end
  end

  // conversion sequencer; wait_mode deliberately unused for control
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= adcc_pkg::ADCC_OFF;
      period_cnt <= 4'h0;
      stab_cnt <= 16'h0000;
    end else if (halt_sync2 || !converter_on) begin
      state <= adcc_pkg::ADCC_OFF;
      period_cnt <= 4'h0;
      stab_cnt <= 16'h0000;
    end else begin
      case (state)
        adcc_pkg::ADCC_OFF: begin
          state <= adcc_pkg::ADCC_STAB;
          stab_cnt <= 16'h0000;
        end
        adcc_pkg::ADCC_STAB: begin
          if (stab_cnt == 16'(adcc_pkg::STAB_CYCLES - 1)) begin
            state <= adcc_pkg::ADCC_CONV;
            period_cnt <= 4'h0;
          end else begin
            stab_cnt <= stab_cnt + 16'h0001;
          end
        end
        adcc_pkg::ADCC_CONV: begin
          if (csr_wr) begin
            period_cnt <= 4'h0;
          end else if (conv_end) begin
            period_cnt <= 4'h0;
          end else if (adc_tick) begin
            period_cnt <= period_cnt + 4'h1;
          end
        end
        default: begin
          state <= adcc_pkg::ADCC_OFF;
        end
      endcase
    end
  end

  // result register and done flag
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      result <= adcc_pkg::RESULT_RESET;
    end else if (conv_end && !csr_wr) begin
      result <= code_sync2;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      conversion_complete_flag <= 1'b0;
    end else if (conv_end && !csr_wr) begin
      conversion_complete_flag <= 1'b1;
    end else if (result_rd || (csr_wr && converter_on)) begin
      conversion_complete_flag <= 1'b0;
    end
  end

  // analog front end drive
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      conv_power <= 1'b0;
      conv_sample <= 1'b0;
      conv_channel <= 4'h0;
      upper_group_en <= 2'b00;
    end else begin
      conv_power <= state != adcc_pkg::ADCC_OFF;
      conv_sample <= state == adcc_pkg::ADCC_CONV && period_cnt < 4'h4;
      conv_channel <= channel_select;
      upper_group_en <= {channel_select[3] && channel_select[2], channel_select[3] && !channel_select[2]};
    end
  end

  // sticky interrupt status, cleared by read, set wins
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (status_rd ? '0 : irq_status) | {abort_ev, conv_end && !csr_wr};
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_mask <= adcc_pkg::MASK_RESET[adcc_pkg::EV_WIDTH-1:0];
    end else if (wr && idx == adcc_pkg::IRQ_MASK_INDEX) begin
      irq_mask <= wb_dat_i[adcc_pkg::EV_WIDTH-1:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // read mux
  always_comb begin
    csr_view = adcc_pkg::CSR_RESET;
    csr_view[adcc_pkg::FLAG_BIT] = conversion_complete_flag;
    csr_view[adcc_pkg::ON_BIT] = converter_on;
    csr_view[CH_W-1:0] = channel_select;
    if (REDUCED_PINS) begin
      csr_view[adcc_pkg::CH_MSB_BIT] = 1'b0;
    end
    next_rdata = 32'h00000000;
    case (idx)
      adcc_pkg::RESULT_INDEX: next_rdata[7:0] = result;
      adcc_pkg::CSR_INDEX: next_rdata[7:0] = csr_view;
      adcc_pkg::IRQ_STATUS_INDEX: next_rdata[adcc_pkg::EV_WIDTH-1:0] = irq_status;
      adcc_pkg::IRQ_MASK_INDEX: next_rdata[adcc_pkg::EV_WIDTH-1:0] = irq_mask;
      adcc_pkg::HALT_CTRL_INDEX: next_rdata[1:0] = {wait_mode, halt_sync2};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // bus answer, one wait state
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= rd ? next_rdata : 32'h00000000;
    end
  end

  // checks
  AST_CONV_LEN: assert property (@(posedge ref_clk) disable iff (!rstn)
    conv_end |-> ##1 (!conv_end) [*8]) else $error("conversions closer than expected");
  AST_FLAG_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
    (conv_end && !csr_wr) |=> conversion_complete_flag) else $error("done flag not set");
  AST_RESULT_LOAD: assert property (@(posedge ref_clk) disable iff (!rstn)
    (conv_end && !csr_wr) |=> result == $past(code_sync2)) else $error("result not loaded");
  AST_RESULT_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
    !$past(conv_end) |-> $stable(result)) else $error("result changed between conversions");
  AST_ABORT: assert property (@(posedge ref_clk) disable iff (!rstn)
    (csr_wr && converter_on) |=> !conversion_complete_flag && period_cnt == 4'h0) else $error("abort failed");
  AST_READ_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (result_rd && !conv_end) |=> !conversion_complete_flag) else $error("read did not clear flag");
  AST_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!converter_on || halt_sync2) |=> ##1 !conv_power) else $error("converter not off");
  AST_ON_START: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($rose(converter_on) && !halt_sync2) |-> ##[1:200] state == adcc_pkg::ADCC_CONV) else $error("no start");
  AST_CH: assert property (@(posedge ref_clk) disable iff (!rstn)
    csr_wr |=> ##1 conv_channel == $past(wb_dat_i[3:0], 2)) else $error("channel not applied");
  COV_CONV: cover property (@(posedge ref_clk) disable iff (!rstn) conv_end);
  COV_ABORT: cover property (@(posedge ref_clk) disable iff (!rstn) abort_ev);
  COV_READ: cover property (@(posedge ref_clk) disable iff (!rstn) result_rd && conversion_complete_flag);
  COV_HALT: cover property (@(posedge ref_clk) disable iff (!rstn) halt_sync2 && converter_on);
  COV_OVERWRITE: cover property (@(posedge ref_clk) disable iff (!rstn) conv_end && conversion_complete_flag);

  // converter timing checks
  AST_TICK_PERIOD: assert property (@(posedge ref_clk) disable iff (!rstn)
    adc_tick |-> ##1 (!adc_tick) [*3]) else $error("converter clock faster than a quarter");
  AST_PERIOD_RANGE: assert property (@(posedge ref_clk) disable iff (!rstn)
    period_cnt <= 4'hB) else $error("period count beyond twelve");
  AST_NEXT_START: assert property (@(posedge ref_clk) disable iff (!rstn)
    (conv_end && !csr_wr && converter_on && !halt_sync2) |=> state == adcc_pkg::ADCC_CONV && period_cnt == 4'h0)
    else $error("next conversion not started at once");
  AST_SAMPLE_POWERED: assert property (@(posedge ref_clk) disable iff (!rstn)
    conv_sample |-> conv_power) else $error("sampling while unpowered");

  // power and mode checks
  AST_POWER_ON: assert property (@(posedge ref_clk) disable iff (!rstn)
    state != adcc_pkg::ADCC_OFF |=> conv_power) else $error("converter not powered");
  AST_OFF_STATE: assert property (@(posedge ref_clk) disable iff (!rstn)
    !converter_on |=> state == adcc_pkg::ADCC_OFF) else $error("sequencer running while off");
  AST_HALT_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
    halt_sync2 |=> state == adcc_pkg::ADCC_OFF) else $error("sequencer running in halt");
  AST_STAB_FIRST: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == adcc_pkg::ADCC_OFF && converter_on && !halt_sync2) |=> state == adcc_pkg::ADCC_STAB)
    else $error("stabilization skipped");

  // result, flag and interrupt mask checks
  AST_FLAG_READ_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
    (result_rd && conv_end && !csr_wr) |=> conversion_complete_flag) else $error("read beat flag set");
  AST_RESULT_RO: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr && idx == adcc_pkg::RESULT_INDEX && !conv_end) |=> $stable(result)) else $error("result written");
  AST_CSR_FLAG_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rd && idx == adcc_pkg::CSR_INDEX) |=> wb_dat_o[7] == $past(conversion_complete_flag))
    else $error("flag misread");
  AST_NO_IRQ_UNMASKED: assert property (@(posedge ref_clk) disable iff (!rstn)
    irq_mask == 2'b00 |=> !irq) else $error("interrupt while all masked");

  // channel and pin checks
  AST_CH_READ_MSB: assert property (@(posedge ref_clk) disable iff (!rstn)
    REDUCED_PINS == 1'b1 |-> !csr_view[adcc_pkg::CH_MSB_BIT]) else $error("channel msb readable");
  AST_UPPER_GROUP: assert property (@(posedge ref_clk) disable iff (!rstn)
    channel_select[3] |=> upper_group_en != 2'b00) else $error("upper group not enabled");
  AST_PIN_PATH: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> pin_logic == $past(pin_sync2)) else $error("pin path broken");

  // bus and interrupt checks
  AST_ACK_DELAY: assert property (@(posedge ref_clk) disable iff (!rstn)
    (req && mapped) |=> wb_ack_o && !wb_err_o) else $error("no acknowledge");
  AST_ACK_PULSE: assert property (@(posedge ref_clk) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o) else $error("acknowledge longer than a cycle");
  AST_ERR_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rstn)
    (req && !mapped) |=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
  AST_DATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn)
    !wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("read data outside acknowledge");
  AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr && idx == adcc_pkg::IRQ_MASK_INDEX) |=> irq_mask == $past(wb_dat_i[1:0])) else $error("mask not written");
  AST_STATUS_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
    (status_rd && !abort_ev && !conv_end) |=> irq_status == 2'b00) else $error("status not cleared");
  AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!rstn)
    (|(irq_status & irq_mask)) |=> irq) else $error("interrupt not raised");
endmodule

// >>> include/adcc_pkg.sv
// package for the adc conversion control block
package adcc_pkg;
  // register indices (printed offsets), byte address = 4 * index
  localparam logic [7:0] RESULT_INDEX = 8'h0A;
  localparam logic [7:0] CSR_INDEX = 8'h0B;
  localparam logic [7:0] IRQ_STATUS_INDEX = 8'h0C;
  localparam logic [7:0] IRQ_MASK_INDEX = 8'h0D;
  localparam logic [7:0] HALT_CTRL_INDEX = 8'h0E;
  // control/status field positions
  localparam int FLAG_BIT = 7;
  localparam int ON_BIT = 5;
  localparam int CH_MSB_BIT = 3;
  localparam int CH_WIDTH = 4;
  // reset values
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // timing
  localparam int CLK_DIV = 4;
  localparam int CONV_PERIODS = 12;
  localparam int CLK_MHZ = 100;
  localparam int STAB_NS = 1000;
  localparam int STAB_CYCLES = (STAB_NS * CLK_MHZ + 999) / 1000;
  // interrupt status bit positions
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_WIDTH = 2;

  typedef enum logic [1:0] {
    ADCC_OFF = 2'b00,
    ADCC_STAB = 2'b01,
    ADCC_CONV = 2'b10
  } adcc_state_type;

  typedef struct packed {
    logic [7:0] code;
    logic [3:0] channel;
  } adcc_sample_type;
endpackage

// >>> testbench/adc_conversion_control_test.sv
// self-checking bench for the adc conversion control
`timescale 1ns/10ps
module adc_conversion_control_test;
  typedef struct {logic [31:0] exp; logic [31:0] msk; logic err;} adcc_note_type;
  logic ref_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
  logic conv_power, conv_sample, wait_mode, halt_mode, irq;
  logic [7:0] wb_adr_i, conv_code, salt;
  logic [3:0] wb_sel_i, conv_channel, ch, ch2;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0] upper_group_en;
  logic [15:0] pin_level, pin_logic;
  adcc_note_type notes[$];
  adcc_note_type n;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int gap, t0;

  adcc_top #(.REDUCED_PINS(1'b1), .NUM_CH(16)) i_adcc_top (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .conv_code, .conv_power, .conv_sample,
    .conv_channel, .upper_group_en, .pin_level, .pin_logic, .wait_mode, .halt_mode, .irq);
  adcc_front_model i_adcc_front_model (.ref_clk, .conv_power, .conv_sample, .conv_channel, .salt, .conv_code);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic compare(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bus watcher takes the oldest note at every answer
  always @(posedge ref_clk) begin
    if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
      n = notes.pop_front();
      compare("bus_err", {31'h0, n.err}, {31'h0, wb_err_o});
      compare("read_data", n.exp & n.msk, wb_dat_o & n.msk);
    end
  end

  task automatic bus(logic we, logic [7:0] idx, logic [7:0] wd, logic [7:0] exp, logic [7:0] msk, logic err);
    notes.push_back('{{24'h0, exp}, {24'h0, msk}, err});
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx[5:0], 2'b00};
    wb_dat_i <= {24'h0, wd};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wait_done();
    do bus(1'b0, adcc_pkg::CSR_INDEX, 8'h00, 8'h00, 8'h00, 1'b0); while (rd[7] !== 1'b1);
  endtask

  initial begin
    void'($urandom(32'h9D80719E));
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wait_mode, halt_mode} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    salt = 8'($urandom);
    pin_level = 16'($urandom);
    ch = 4'($urandom_range(7, 0));
    ch2 = {1'b0, ch[2:0] ^ 3'h5};
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    compare("pin_logic", {16'h0, pin_level}, {16'h0, pin_logic});
    bus(1'b0, adcc_pkg::RESULT_INDEX, 8'h00, adcc_pkg::RESULT_RESET, 8'hFF, 1'b0);
    bus(1'b1, adcc_pkg::RESULT_INDEX, 8'h5A, 8'h00, 8'h00, 1'b0);
    bus(1'b0, adcc_pkg::RESULT_INDEX, 8'h00, 8'h00, 8'hFF, 1'b0);
    bus(1'b0, 8'h3F, 8'h00, 8'h00, 8'h00, 1'b1);
    bus(1'b1, adcc_pkg::IRQ_MASK_INDEX, 8'h01, 8'h00, 8'h00, 1'b0);
    bus(1'b1, adcc_pkg::CSR_INDEX, {4'h2, ch}, 8'h00, 8'h00, 1'b0);
    wait_done();
    compare("csr_flag", {24'h0, 4'hA, ch}, rd);
    bus(1'b0, adcc_pkg::RESULT_INDEX, 8'h00, salt ^ {4'h0, ch}, 8'hFF, 1'b0);
    bus(1'b0, adcc_pkg::CSR_INDEX, 8'h00, {4'h2, ch}, 8'hFF, 1'b0);
    compare("irq", 32'h1, {31'h0, irq});
    bus(1'b0, adcc_pkg::IRQ_STATUS_INDEX, 8'h00, 8'h01, 8'h01, 1'b0);
    repeat (2) @(posedge ref_clk);
    compare("irq", 32'h0, {31'h0, irq});
    @(posedge conv_sample);
    gap = 0;
    fork
      forever begin
        @(posedge ref_clk);
        gap++;
      end
      @(posedge conv_sample);
    join_any
    disable fork;
    compare("conv_period", adcc_pkg::CLK_DIV * adcc_pkg::CONV_PERIODS, gap);
    wait_mode <= 1'b1;
    bus(1'b0, adcc_pkg::HALT_CTRL_INDEX, 8'h00, 8'h02, 8'h03, 1'b0);
    wait_done();
    bus(1'b1, adcc_pkg::CSR_INDEX, {4'h2, ch2}, 8'h00, 8'h00, 1'b0);
    bus(1'b0, adcc_pkg::CSR_INDEX, 8'h00, {4'h2, ch2}, 8'hFF, 1'b0);
    bus(1'b0, adcc_pkg::IRQ_STATUS_INDEX, 8'h00, 8'h02, 8'h02, 1'b0);
    wait_done();
    bus(1'b0, adcc_pkg::RESULT_INDEX, 8'h00, salt ^ {4'h0, ch2}, 8'hFF, 1'b0);
    halt_mode <= 1'b1;
    repeat (6) @(posedge ref_clk);
    compare("conv_power", 32'h0, {31'h0, conv_power});
    bus(1'b0, adcc_pkg::RESULT_INDEX, 8'h00, 8'h00, 8'h00, 1'b0);
    halt_mode <= 1'b0;
    t0 = cycles;
    wait_done();
    compare("wake_delay", 32'h1, {31'h0, (cycles - t0) >= adcc_pkg::STAB_CYCLES + 48});
    bus(1'b1, adcc_pkg::CSR_INDEX, 8'h2C, 8'h00, 8'h00, 1'b0);
    bus(1'b0, adcc_pkg::CSR_INDEX, 8'h00, 8'h24, 8'hFF, 1'b0);
    compare("upper_group", 32'h1, {31'h0, |upper_group_en});
    bus(1'b1, adcc_pkg::CSR_INDEX, 8'h00, 8'h00, 8'h00, 1'b0);
    repeat (4) @(posedge ref_clk);
    compare("conv_power", 32'h0, {31'h0, conv_power});
    final_report();
  end
endmodule

// >>> testbench/adcc_front_model.sv
// analog front end model: sample and hold fed by the selected channel
`timescale 1ns/10ps
module adcc_front_model (
  // clock
  input wire logic ref_clk,
  // converter control
  input wire logic conv_power,
  input wire logic conv_sample,
  input wire logic [3:0] conv_channel,
  // channel level offset from the bench
  input wire logic [7:0] salt,
  // converter output
  output logic [7:0] conv_code
);
  initial conv_code = 8'h00;
  always @(posedge ref_clk) begin
    if (!conv_power) begin
      conv_code <= ~conv_code;
    end else if (conv_sample) begin
      conv_code <= salt ^ {4'h0, conv_channel};
    end
  end
endmodule
